//--- core/rtc_core.sv
// Summary of operation
// - count from main or low-power oscillator; may keep counting in idle or power-down
// - when enabled, interrupt each basic tick and after n programmable ticks
// - provide a 58-bit long-term measurement timer
// - with wake configuration set, leave power-down after the programmed delay
// - divide input clock by fixed 64, then by a 20-bit divider counter
// - reload the 20-bit divider from the prescale register every tick
// - issue a tick interrupt request on each basic tick
// - 32-bit time counter, preloadable by software, advances once per tick
// - compare time counter with alarm register; request alarm on equality
// - tick and alarm requests feed external interrupt select; alarm and n-tick requests feed power-down wake
// - oscillator-off bit switches the clock oscillator off at power-down entry
// - disabled block switches both oscillators off in power-down
// - after reset detect low-power oscillation and select it if present
// - with low-power reference, power-down stops or keeps counter; main oscillator off
// - with low-power reference, counter keeps running in stand-by
// - without it, main oscillator drives counter, kept on in power-down unless disabled or oscillator-off bit set
// - all registers reached only through the peripheral bus
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"

module rtc_core
	import rtc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// chip power state and oscillator pins
	input wire logic [2:0] powerMode,
	input wire logic standby,
	input wire logic lowpowerOscIn,
	output logic mainOscEnable,
	output logic lowpowerOscEnable,
	// requests to the external interrupt selector and wake logic
	output logic tickIrq,
	output logic alarmIrq,
	output logic wakeReq
);
	logic [`RTC_CTRL_W-1:0] ctrl_r;
	logic [`RTC_DIV_W-1:0] reload_r;
	logic [`RTC_DIV_W-1:0] div_r;
	logic [`RTC_FIX_DIV_W-1:0] fix_r;
	logic [31:0] time_r;
	logic [31:0] alarm_r;
	logic [31:0] nTick_r;
	logic [31:0] nCnt_r;
	logic [`RTC_LONG_W-1:0] long_r;
	logic [2:0] status_r;
	rtc_req_t req_r;
	logic reqValid_r;
	logic detDone;
	logic lpPresent;
	logic counting;
	logic fixWrap;
	logic tick;
	logic nTickHit;
	logic alarmHit;
	logic inPd;
	logic wrEn;
	logic [31:0] rdData;
	rtc_pmode_t pmode;

	assign pmode = rtc_pmode_t'(powerMode);
	assign inPd = (pmode == RTC_PD_MODE);

	rtc_osc_detect u_det (
		.clk(clk),
		.reset(reset),
		.lowpowerOscIn(lowpowerOscIn),
		.detDone(detDone),
		.lpPresent(lpPresent)
	);

	// decide whether the chain runs in the present power state
	always_comb
	begin
		counting = ctrl_r[`RTC_CTRL_RUN] && detDone;
		unique case (pmode)
			RTC_RUN_MODE: ; // run leaves the chain as enabled
			RTC_IDLE_MODE: ;
			RTC_PD_MODE: counting = counting && !ctrl_r[`RTC_CTRL_PD_STOP]
				&& !ctrl_r[`RTC_CTRL_OSC_OFF];
			default: counting = 1'b0;
		endcase
		// stand-by keeps only the low-power reference alive
		// power-down stop bits still apply when stand-by is entered from power-down
		if (standby && !lpPresent)
			counting = 1'b0;
	end

	// fixed divide by 64 in front of the reloadable divider
	assign fixWrap = counting && (fix_r == `RTC_FIX_DIV_MAX);
	assign tick = fixWrap && (div_r == '0);

	always_ff @(posedge clk)
	begin
		if (reset)
			fix_r <= '0;
		else if (counting)
			fix_r <= fix_r + 1'b1;
	end

	// 20-bit divider counts down and reloads at expiry
	always_ff @(posedge clk)
	begin
		if (reset)
			div_r <= `RTC_RELOAD_RST;
		else if (fixWrap)
			div_r <= (div_r == '0) ? reload_r : div_r - 1'b1;
	end

	// time counter wraps naturally from all ones to zero
	always_ff @(posedge clk)
	begin
		if (reset)
			time_r <= '0;
		else if (wrEn && req_r.addr == `RTC_OFF_TIME)
			time_r <= hwdata;
		else if (tick)
			time_r <= time_r + 32'h1;
	end

	// 58-bit measurement timer advances with each basic tick
	always_ff @(posedge clk)
	begin
		if (reset)
			long_r <= '0;
		else if (tick)
			long_r <= long_r + 58'h1;
	end

	// n-tick counter for the programmable cyclic request
	assign nTickHit = tick && (nCnt_r >= nTick_r);
	always_ff @(posedge clk)
	begin
		if (reset)
			nCnt_r <= '0;
		else if (tick)
			nCnt_r <= nTickHit ? 32'h0 : nCnt_r + 32'h1;
	end

	// match only on the tick that lands on the alarm value, so it fires once
	assign alarmHit = tick && ((time_r + 32'h1) == alarm_r);

	// sticky flags: a new event wins over a simultaneous clear
	always_ff @(posedge clk)
	begin
		if (reset)
			status_r <= '0;
		else
		begin
			for (int i = 0; i < 3; i++)
				if (wrEn && req_r.addr == `RTC_OFF_STATUS && hwdata[i])
					status_r[i] <= 1'b0;
			if (tick && ctrl_r[`RTC_CTRL_TICK_EN])
				status_r[`RTC_ST_TICK] <= 1'b1;
			if (nTickHit && ctrl_r[`RTC_CTRL_NTICK_EN])
				status_r[`RTC_ST_NTICK] <= 1'b1;
			if (alarmHit && ctrl_r[`RTC_CTRL_ALARM_EN])
				status_r[`RTC_ST_ALARM] <= 1'b1;
		end
	end

	// request lines toward the port-2 selector and wake logic
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tickIrq <= 1'b0;
			alarmIrq <= 1'b0;
			wakeReq <= 1'b0;
		end
		else
		begin
			tickIrq <= tick && (ctrl_r[`RTC_CTRL_TICK_EN] || (nTickHit
				&& ctrl_r[`RTC_CTRL_NTICK_EN]));
			alarmIrq <= alarmHit && ctrl_r[`RTC_CTRL_ALARM_EN];
			wakeReq <= inPd && ctrl_r[`RTC_CTRL_PD_WAKE] && ((alarmHit
				&& ctrl_r[`RTC_CTRL_ALARM_EN]) || (nTickHit
				&& ctrl_r[`RTC_CTRL_NTICK_EN]));
		end
	end

	// oscillator enables for the present power state
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mainOscEnable <= 1'b1;
			lowpowerOscEnable <= 1'b1;
		end
		else if (inPd)
		begin
			if (!ctrl_r[`RTC_CTRL_RUN])
			begin
				mainOscEnable <= 1'b0;
				lowpowerOscEnable <= 1'b0;
			end
			else if (lpPresent)
			begin
				mainOscEnable <= 1'b0;
				lowpowerOscEnable <= !ctrl_r[`RTC_CTRL_OSC_OFF];
			end
			else
			begin
				mainOscEnable <= !ctrl_r[`RTC_CTRL_OSC_OFF];
				lowpowerOscEnable <= 1'b0;
			end
		end
		else
		begin
			mainOscEnable <= !standby;
			lowpowerOscEnable <= lpPresent || !detDone;
		end
	end

	// bus address phase capture; zero wait states
	assign wrEn = reqValid_r && req_r.write;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			reqValid_r <= 1'b0;
			req_r <= '0;
		end
		else if (hready)
		begin
			reqValid_r <= hsel && htrans[1];
			req_r.write <= hwrite;
			req_r.addr <= haddr[7:0];
		end
	end

	// software-written registers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl_r <= `RTC_CTRL_RST;
			reload_r <= `RTC_RELOAD_RST;
			alarm_r <= '0;
			nTick_r <= '0;
		end
		else if (wrEn)
		begin
			unique case (req_r.addr)
				`RTC_OFF_CTRL: ctrl_r <= hwdata[`RTC_CTRL_W-1:0];
				`RTC_OFF_RELOAD: reload_r <= hwdata[`RTC_DIV_W-1:0];
				`RTC_OFF_ALARM: alarm_r <= hwdata;
				`RTC_OFF_NTICK: nTick_r <= hwdata;
				default: ;
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		rdData = '0;
		unique case (haddr[7:0])
			`RTC_OFF_CTRL: rdData[`RTC_CTRL_W-1:0] = ctrl_r;
			`RTC_OFF_STATUS: rdData = {28'h0, lpPresent, status_r};
			`RTC_OFF_RELOAD: rdData[`RTC_DIV_W-1:0] = reload_r;
			`RTC_OFF_TIME: rdData = time_r;
			`RTC_OFF_ALARM: rdData = alarm_r;
			`RTC_OFF_NTICK: rdData = nTick_r;
			`RTC_OFF_LONG_LO: rdData = long_r[31:0];
			`RTC_OFF_LONG_HI: rdData[`RTC_LONG_HI_W-1:0] = long_r[`RTC_LONG_W-1:32];
			default: rdData = '0;
		endcase
	end

	// read data registered in the data phase
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite)
				hrdata <= rdData;
		end
	end

	// tick follows divider expiry on the fixed-prescale wrap
	// a resumed chain may wrap at once, so only a running prescaler is held to its step
	tick_cause_a: assert property (@(posedge clk) disable iff (reset)
		tick && $past(counting) |-> $past(fix_r) + 6'h01 == `RTC_FIX_DIV_MAX)
		else $error("tick without prescale wrap");
	// divider reload
	div_reload_a: assert property (@(posedge clk) disable iff (reset)
		tick |=> div_r == $past(reload_r)) else $error("divider not reloaded");
	// time counter step
	time_step_a: assert property (@(posedge clk) disable iff (reset)
		tick && !wrEn |=> time_r == $past(time_r) + 32'h1) else $error("time not advanced");
	// alarm request follows equality
	alarm_req_a: assert property (@(posedge clk) disable iff (reset)
		alarmIrq |-> time_r == alarm_r) else $error("alarm without match");
	// alarm single shot
	alarm_once_a: assert property (@(posedge clk) disable iff (reset)
		alarmIrq |=> !alarmIrq) else $error("alarm repeated");
	// disabled block stops oscillators in power-down
	osc_stop_a: assert property (@(posedge clk) disable iff (reset)
		inPd && !ctrl_r[`RTC_CTRL_RUN] |=> !mainOscEnable && !lowpowerOscEnable)
		else $error("oscillators left on");
	// oscillator-off bit honoured in power-down
	osc_off_a: assert property (@(posedge clk) disable iff (reset)
		inPd && ctrl_r[`RTC_CTRL_OSC_OFF] |-> !counting) else $error("counting with osc off");
	// low-power reference turns main oscillator off in power-down
	main_off_a: assert property (@(posedge clk) disable iff (reset)
		inPd && lpPresent |=> !mainOscEnable) else $error("main osc kept on");
	// wake only with configuration set
	wake_cfg_a: assert property (@(posedge clk) disable iff (reset)
		wakeReq |-> $past(ctrl_r[`RTC_CTRL_PD_WAKE]) && $past(inPd))
		else $error("wake without configuration");
	// tick requests only when counting
	tick_irq_a: assert property (@(posedge clk) disable iff (reset)
		tickIrq |-> $past(tick)) else $error("tick request without tick");
endmodule
`default_nettype wire

//--- core/rtc_defines.svh
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// register byte offsets on the AHB-Lite slave
`define RTC_OFF_CTRL 8'h00
`define RTC_OFF_STATUS 8'h04
`define RTC_OFF_RELOAD 8'h08
`define RTC_OFF_TIME 8'h0c
`define RTC_OFF_ALARM 8'h10
`define RTC_OFF_NTICK 8'h14
`define RTC_OFF_LONG_LO 8'h18
`define RTC_OFF_LONG_HI 8'h1c

// control register fields
`define RTC_CTRL_RUN 0
`define RTC_CTRL_TICK_EN 1
`define RTC_CTRL_NTICK_EN 2
`define RTC_CTRL_ALARM_EN 3
`define RTC_CTRL_OSC_OFF 4
`define RTC_CTRL_PD_STOP 5
`define RTC_CTRL_PD_WAKE 6
`define RTC_CTRL_W 7
`define RTC_CTRL_RST 7'h01

// status register fields; bits 0-2 written one to clear, bit 3 read-only
`define RTC_ST_TICK 0
`define RTC_ST_NTICK 1
`define RTC_ST_ALARM 2
`define RTC_ST_LP_SEL 3

// prescale and counter widths
`define RTC_FIX_DIV_W 6
`define RTC_FIX_DIV_MAX 6'h3f
`define RTC_DIV_W 20
`define RTC_RELOAD_RST 20'h00000
`define RTC_LONG_W 58
`define RTC_LONG_HI_W 26

// low-power oscillator detection window, in clk cycles
`define RTC_DET_W 12
`define RTC_DET_WINDOW 12'hfff
`define RTC_DET_EDGES 4'h8

`endif

//--- core/rtc_pkg.sv
package rtc_pkg;
	// one bus request as seen in the address phase
	typedef struct packed {
		logic write;
		logic [7:0] addr;
	} rtc_req_t;

	// power mode of the chip
	typedef enum logic [2:0] {
		RTC_RUN_MODE = 3'b001,
		RTC_IDLE_MODE = 3'b010,
		RTC_PD_MODE = 3'b100
	} rtc_pmode_t;

	// event pulses produced by the counter chain
	typedef struct packed {
		logic tick;
		logic ntick;
		logic alarm;
	} rtc_evt_t;
endpackage

//--- core/rtc_osc_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"

// watches the low-power oscillator pin after reset and decides whether it toggles
module rtc_osc_detect
	import rtc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// oscillator sample
	input wire logic lowpowerOscIn,
	// result
	output logic detDone,
	output logic lpPresent
);
	logic [`RTC_DET_W-1:0] winCnt_r;
	logic [3:0] edgeCnt_r;
	logic lastLevel_r;

	// count window and edges; a few edges suffice so a stuck pin never selects it
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			winCnt_r <= '0;
			edgeCnt_r <= '0;
			lastLevel_r <= 1'b0;
			detDone <= 1'b0;
			lpPresent <= 1'b0;
		end
		else if (!detDone)
		begin
			lastLevel_r <= lowpowerOscIn;
			winCnt_r <= winCnt_r + 1'b1;
			// the first sample only primes the level, so a pin resting high is no edge
			if (winCnt_r != '0 && lowpowerOscIn != lastLevel_r
				&& edgeCnt_r != `RTC_DET_EDGES)
				edgeCnt_r <= edgeCnt_r + 4'h1;
			if (winCnt_r == `RTC_DET_WINDOW)
			begin
				detDone <= 1'b1;
				lpPresent <= (edgeCnt_r == `RTC_DET_EDGES);
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/rtc_prescaled_alarm_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"

module rtc_prescaled_alarm_counter_bench
	import rtc_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [2:0] powerMode = RTC_RUN_MODE;
	logic standby = 1'b0;
	logic lowpowerOscIn = 1'b0;
	logic lpOn = 1'b1;
	logic [3:0] lpDiv = 4'h0;
	logic [31:0] hrdata;
	logic hready, hresp, mainOscEnable, lowpowerOscEnable, tickIrq, alarmIrq, wakeReq;
	int mismatches = 0;
	int compares = 0;
	localparam logic [31:0] runBit = 32'h1 << `RTC_CTRL_RUN;
	localparam logic [31:0] tickEn = 32'h1 << `RTC_CTRL_TICK_EN;
	localparam logic [31:0] ntickEn = 32'h1 << `RTC_CTRL_NTICK_EN;
	localparam logic [31:0] alarmEn = 32'h1 << `RTC_CTRL_ALARM_EN;
	localparam logic [31:0] oscOff = 32'h1 << `RTC_CTRL_OSC_OFF;
	localparam logic [31:0] pdStop = 32'h1 << `RTC_CTRL_PD_STOP;
	localparam logic [31:0] pdWake = 32'h1 << `RTC_CTRL_PD_WAKE;

	always #5 clk = ~clk;

	// low-power oscillator stand-in: one edge every 16 cycles, far above the detect threshold
	always @(posedge clk)
	begin
		lpDiv <= lpDiv + 4'h1;
		if (lpOn && lpDiv == 4'h0)
			lowpowerOscIn <= ~lowpowerOscIn;
	end

	rtc_core u_rtc_core (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .powerMode(powerMode), .standby(standby),
		.lowpowerOscIn(lowpowerOscIn), .mainOscEnable(mainOscEnable),
		.lowpowerOscEnable(lowpowerOscEnable), .tickIrq(tickIrq), .alarmIrq(alarmIrq),
		.wakeReq(wakeReq));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic gaveUp();
		mismatches++;
		$display("CHECK FAILED wait expected done seen timeout");
		report_and_stop();
	endtask

	// one single transfer; entered right after a rising edge, never assumes a latency
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		for (int ph = 0; ph < 2; ph++)
		begin
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (hready !== 1'b1 && n < 50);
			if (n >= 50)
				gaveUp();
			// only the address phase ends here; a following call may raise htrans at once
			if (ph == 0)
			begin
				htrans <= 2'b00;
				hsel <= 1'b0;
				hwdata <= d;
			end
		end
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		check(what, x & m, exp);
	endtask

	function automatic logic pick(input int which);
		return which == 0 ? tickIrq : which == 1 ? alarmIrq : wakeReq;
	endfunction

	// cycles until the chosen request pulses
	task automatic waitIrq(input int which, output int c);
		c = 0;
		do
		begin
			@(posedge clk);
			c++;
		end
		while (pick(which) !== 1'b1 && c < 2000);
		if (c >= 2000)
			gaveUp();
	endtask

	task automatic countIrq(input int which, input int len, output int n);
		n = 0;
		repeat (len)
		begin
			@(posedge clk);
			if (pick(which) === 1'b1)
				n++;
		end
	endtask

	task automatic doReset(input logic lp);
		lpOn <= lp;
		reset <= 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask

	task automatic t_regs();
		check("hresp", 32'(hresp), 32'h0);
		rdChk("ctrl reset", `RTC_OFF_CTRL, 32'h7f, {25'h0, `RTC_CTRL_RST});
		rdChk("reload reset", `RTC_OFF_RELOAD, 32'hfffff, 32'h0);
		wr(8'h20, 32'hffffffff);
		rdChk("unmapped", 8'h20, 32'hffffffff, 32'h0);
		wr(`RTC_OFF_CTRL, 32'h0);
		wr(`RTC_OFF_TIME, 32'h00001234);
		rdChk("time preload", `RTC_OFF_TIME, 32'hffffffff, 32'h00001234);
		rdChk("long hi width", `RTC_OFF_LONG_HI, 32'hfc000000, 32'h0);
		repeat (4100) @(posedge clk);
		rdChk("lp selected", `RTC_OFF_STATUS, 32'h8, 32'h8);
	endtask

	task automatic t_tick();
		int c;
		logic [31:0] a, b;
		wr(`RTC_OFF_TIME, 32'hffffffff);
		wr(`RTC_OFF_NTICK, 32'h0000ffff);
		bus(1'b0, `RTC_OFF_LONG_LO, 32'h0, a);
		wr(`RTC_OFF_CTRL, runBit | tickEn);
		waitIrq(0, c);
		@(posedge clk);
		check("tick pulse width", 32'(tickIrq), 32'h0);
		waitIrq(0, c);
		check("tick period r0", 32'(c + 1), 32'h40);
		wr(`RTC_OFF_CTRL, 32'h0);
		rdChk("time wrap", `RTC_OFF_TIME, 32'hffffffff, 32'h1);
		bus(1'b0, `RTC_OFF_LONG_LO, 32'h0, b);
		check("long timer", b - a, 32'h2);
		wr(`RTC_OFF_RELOAD, 32'h2);
		wr(`RTC_OFF_CTRL, runBit | tickEn);
		waitIrq(0, c);
		waitIrq(0, c);
		check("tick period r2", 32'(c), 32'hc0);
		wr(`RTC_OFF_CTRL, 32'h0);
		wr(`RTC_OFF_RELOAD, 32'h0);
		wr(`RTC_OFF_NTICK, 32'h2);
		wr(`RTC_OFF_CTRL, runBit | ntickEn);
		waitIrq(0, c);
		waitIrq(0, c);
		check("n tick period", 32'(c), 32'hc0);
	endtask

	task automatic t_alarm();
		int n;
		wr(`RTC_OFF_CTRL, 32'h0);
		wr(`RTC_OFF_STATUS, 32'h7);
		wr(`RTC_OFF_TIME, 32'h0a);
		wr(`RTC_OFF_ALARM, 32'h0c);
		wr(`RTC_OFF_CTRL, runBit | alarmEn);
		countIrq(1, 400, n);
		check("alarm pulses", 32'(n), 32'h1);
		wr(`RTC_OFF_CTRL, 32'h0);
		rdChk("alarm flag", `RTC_OFF_STATUS, 32'h4, 32'h4);
		wr(`RTC_OFF_STATUS, 32'h4);
		rdChk("alarm cleared", `RTC_OFF_STATUS, 32'h4, 32'h0);
	endtask

	// low-power reference selected: power-down and stand-by behaviour
	task automatic t_power();
		int n;
		wr(`RTC_OFF_NTICK, 32'h0000ffff);
		wr(`RTC_OFF_TIME, 32'h0);
		wr(`RTC_OFF_ALARM, 32'h2);
		wr(`RTC_OFF_CTRL, runBit | tickEn | alarmEn | pdWake);
		powerMode <= RTC_PD_MODE;
		repeat (8) @(posedge clk);
		check("main osc pd", 32'(mainOscEnable), 32'h0);
		check("lp osc pd", 32'(lowpowerOscEnable), 32'h1);
		countIrq(2, 300, n);
		check("wake pulses", 32'(n), 32'h1);
		waitIrq(0, n);
		countIrq(0, 256, n);
		check("ticks in pd", 32'(n), 32'h4);
		wr(`RTC_OFF_CTRL, runBit | tickEn | pdStop);
		repeat (70) @(posedge clk);
		countIrq(0, 256, n);
		check("ticks pd stop", 32'(n), 32'h0);
		wr(`RTC_OFF_CTRL, runBit | oscOff);
		repeat (8) @(posedge clk);
		check("osc off", 32'(lowpowerOscEnable), 32'h0);
		wr(`RTC_OFF_CTRL, 32'h0);
		repeat (8) @(posedge clk);
		check("disabled both off", 32'({mainOscEnable, lowpowerOscEnable}), 32'h0);
		powerMode <= RTC_RUN_MODE;
		wr(`RTC_OFF_CTRL, runBit | tickEn);
		standby <= 1'b1;
		waitIrq(0, n);
		countIrq(0, 256, n);
		check("ticks standby lp", 32'(n), 32'h4);
		standby <= 1'b0;
		powerMode <= RTC_IDLE_MODE;
		countIrq(0, 256, n);
		check("ticks idle", 32'(n), 32'h4);
	endtask

	// no oscillation during detection: main oscillator is the reference
	task automatic t_main();
		int n;
		doReset(1'b0);
		repeat (4100) @(posedge clk);
		rdChk("lp absent", `RTC_OFF_STATUS, 32'h8, 32'h0);
		wr(`RTC_OFF_CTRL, runBit | tickEn);
		powerMode <= RTC_PD_MODE;
		repeat (8) @(posedge clk);
		check("main osc kept", 32'(mainOscEnable), 32'h1);
		powerMode <= RTC_RUN_MODE;
		standby <= 1'b1;
		repeat (70) @(posedge clk);
		countIrq(0, 256, n);
		check("ticks standby main", 32'(n), 32'h0);
	endtask

	initial
	begin
		doReset(1'b1);
		t_regs();
		t_tick();
		t_alarm();
		t_power();
		t_main();
		report_and_stop();
	end
endmodule

`default_nettype wire
